// *** verilog/gfm_pkg.sv ***
// Constants, register map and carrier types for the pin function multiplexer
package gfm_pkg;
  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int          NPINS         = 16;
  localparam int          NEVENTS       = 18;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          DEB_TIME_US   = 10;
  localparam int          DEB_CYCLES    = (DEB_TIME_US * 1000) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_PIN_CFG0  = 16'h0000;
  localparam logic [15:0] IDX_EVENT     = 16'h0010;
  localparam logic [15:0] IDX_MASK_ONE  = 16'h0011;
  localparam logic [15:0] IDX_MASK_TWO  = 16'h0012;
  localparam logic [15:0] IDX_JTAG      = 16'h0013;
  localparam logic [15:0] IDX_LOOP1_CLK = 16'h018E;
  localparam logic [15:0] IDX_LOOP2_CLK = 16'h01AE;
  // ----------------------------------------------------------------------
  // Function codes, field layout and reset values
  // ----------------------------------------------------------------------
  localparam logic [9:0]  FN_ALT        = 10'h000;
  localparam logic [9:0]  FN_LEVEL      = 10'h001;
  localparam logic [9:0]  FN_DSP        = 10'h002;
  localparam logic [9:0]  FN_REQ_ONE    = 10'h003;
  localparam logic [9:0]  FN_REQ_TWO    = 10'h004;
  localparam logic [9:0]  FN_LOOP1_CLK  = 10'h010;
  localparam logic [9:0]  FN_LOOP2_CLK  = 10'h011;
  localparam logic [9:0]  FN_LOOP1_LOCK = 10'h018;
  localparam logic [9:0]  FN_LOOP2_LOCK = 10'h019;
  localparam int          CFG_W         = 15;
  localparam int          DIV_LSB       = 1;
  localparam int          ENA_BIT       = 0;
  localparam logic [6:0]  DIV_RESET     = 7'h02;
  localparam logic [6:0]  DIV_MIN       = 7'h02;
  localparam logic [17:0] MASK_RESET    = 18'h3FFFF;
  // ----------------------------------------------------------------------
  // Per-pin alternate function table (bit 0 is pin 1)
  // ----------------------------------------------------------------------
  localparam logic [15:0] ALT_OUT_PINS  = 16'h111C;
  localparam logic [15:0] ALT_IO_PINS   = 16'hAAA0;
  localparam logic [15:0] ALT_IN_PINS   = 16'h4440;
  localparam logic [15:0] JTAG_PINS     = 16'h7000;
  localparam logic [15:0] JTAG_OUT_PINS = 16'h1000;
  localparam logic [15:0] LOW_FOUR_PINS = 16'h000F;

  // Pin configuration word, bits 14:0
  typedef struct packed {
    logic       dir;     // 1 = input
    logic       pol;     // 1 = inverted output
    logic       odrain;  // 1 = open drain
    logic       lvl;     // Written output level
    logic       deb_en;  // Input debounce enable
    logic [9:0] fn;      // Function select
  } gfm_pin_cfg_t;

  localparam gfm_pin_cfg_t CFG_RESET = '{dir: 1'b1, pol: 1'b0, odrain: 1'b0, lvl: 1'b0,
                                         deb_en: 1'b0, fn: FN_LEVEL};

  // Audio port drive from the core, toward the pins
  typedef struct packed {
    logic tx;
    logic bclk;
    logic bclk_drv;
    logic frm;
    logic frm_drv;
  } gfm_aif_out_t;

  // Audio port levels from the pins, toward the core
  typedef struct packed {
    logic rx;
    logic bclk;
    logic frm;
  } gfm_aif_in_t;
endpackage : gfm_pkg

// *** verilog/gfm_top.sv ***
// Pin function multiplexer with APB configuration, debounce, events and clock outputs
// Operation
// [R1] Pins 1-2 plain; 14 pins have alternates
// [R2] Code 0x000 selects pin's own alternate
// [R3] Alternate fixes direction and driver type
// [R4] Port 1 on pins 5 to 8
// [R5] Port 2 on pins 9 to 12
// [R6] Port 3 on pins 13 to 16
// [R7] Pins 3-4 carry speaker PDM clock/data
// [R8] JTAG enable takes over pins 13-15
// [R9] Code 0x001 input reads debounced level
// [R10] Software should enable debounce for buttons
// [R11] Debounced edges both ways latch events
// [R12] Logic output drives the written level
// [R13] Level field write-only on output pins
// [R14] Polarity bit inverts driven level
// [R15] Code 0x002 hands pin to DSP
// [R16] Codes 0x003/0x004 output request lines
// [R17] Request one always on dedicated pin
// [R18] Every event individually maskable per line
// [R19] Codes 0x010/0x011 output divided loop clocks
// [R20] Enable bit gates each loop clock output
// [R21] Divider never alters the loop itself
// [R22] Software disables clock before changing divider
// [R23] Codes 0x018/0x019 output loop lock flags
// [R24] Lock flag edges latch events
`timescale 1ns/10ps
module gfm_top
  import gfm_pkg::*;
#(
  parameter int DEB_CYC = DEB_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [17:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output      logic [31:0]         prdata,
  output      logic                pready,
  output      logic                pslverr,
  input  wire logic [NPINS-1:0]    pad_in,
  output      logic [NPINS-1:0]    pad_out,
  output      logic [NPINS-1:0]    pad_oe_n,
  input  wire gfm_aif_out_t [2:0]  aif_from_core,
  output      gfm_aif_in_t  [2:0]  aif_to_core,
  input  wire logic                speaker_pdm_clock,
  input  wire logic                speaker_pdm_data,
  input  wire logic [NPINS-1:0]    dsp_out,
  input  wire logic [NPINS-1:0]    dsp_drive,
  output      logic [NPINS-1:0]    dsp_in,
  input  wire logic                jtag_tdo,
  output      logic [1:0]          jtag_in,
  input  wire logic [1:0]          loop_clk,
  input  wire logic [1:0]          loop_lock,
  output      logic                request_line_one,
  output      logic                request_line_two,
  output      logic                irq_pin
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  gfm_pin_cfg_t             cfg_reg [NPINS];
  logic [NEVENTS-1:0]       event_reg;
  logic [NEVENTS-1:0]       mask_one_reg;
  logic [NEVENTS-1:0]       mask_two_reg;
  logic                     jtag_en_reg;
  logic [6:0]               div_reg [2];
  logic [1:0]               clk_en_reg;
  logic [19:0]              sync1_reg;
  logic [19:0]              sync2_reg;
  logic [19:0]              sync3_reg;
  logic [19:0]              filt_reg;
  logic [NPINS-1:0]         deb_reg;
  logic [NPINS-1:0]         deb_d_reg;
  logic [1:0]               lock_d_reg;
  logic [1:0]               gclk_reg;
  logic [31:0]              prdata_reg;
  logic                     pslverr_reg;
  logic [NPINS-1:0]         pad_out_reg;
  logic [NPINS-1:0]         pad_oe_n_reg;

  logic [15:0]              idx;
  logic                     wr_en;
  logic                     rd_setup;
  logic                     mapped;
  logic [31:0]              rd_next;
  logic [NEVENTS-1:0]       event_set;
  logic [NEVENTS-1:0]       event_clr;
  logic [NPINS-1:0]         alt_val;
  logic [NPINS-1:0]         alt_drv;
  logic [NPINS-1:0]         pad_out_next;
  logic [NPINS-1:0]         pad_oe_n_next;
  logic [NPINS-1:0]         alt_sel;
  logic [NPINS-1:0]         in_level;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero wait states; read data is captured in the setup cycle
  assign idx      = paddr[17:2];
  assign wr_en    = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable;
  assign pready   = psel & penable;
  assign prdata   = prdata_reg;
  assign pslverr  = pslverr_reg;

  always_comb begin
    mapped = (paddr[1:0] == 2'b00) &&
             ((idx < IDX_PIN_CFG0 + 16'(NPINS)) || (idx == IDX_EVENT) ||
              (idx == IDX_MASK_ONE) || (idx == IDX_MASK_TWO) || (idx == IDX_JTAG) ||
              (idx == IDX_LOOP1_CLK) || (idx == IDX_LOOP2_CLK));
  end

  // Read multiplexer; output pins read their level field as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (idx < IDX_PIN_CFG0 + 16'(NPINS)) begin
      rd_next[CFG_W-1:0] = cfg_reg[idx[3:0]];
      rd_next[11]        = cfg_reg[idx[3:0]].dir & deb_reg[idx[3:0]]; // R9 R13
    end else if (idx == IDX_EVENT) begin
      rd_next[NEVENTS-1:0] = event_reg;
    end else if (idx == IDX_MASK_ONE) begin
      rd_next[NEVENTS-1:0] = mask_one_reg;
    end else if (idx == IDX_MASK_TWO) begin
      rd_next[NEVENTS-1:0] = mask_two_reg;
    end else if (idx == IDX_JTAG) begin
      rd_next[0] = jtag_en_reg;
    end else if (idx == IDX_LOOP1_CLK) begin
      rd_next[7:0] = {div_reg[0], clk_en_reg[0]};
    end else if (idx == IDX_LOOP2_CLK) begin
      rd_next[7:0] = {div_reg[1], clk_en_reg[1]};
    end
  end

  // Read data and error flag, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (rd_setup) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
      pslverr_reg <= ~mapped;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Pin configuration words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPINS; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
    end else if (wr_en && (idx < IDX_PIN_CFG0 + 16'(NPINS))) begin
      cfg_reg[idx[3:0]] <= gfm_pin_cfg_t'(pwdata[CFG_W-1:0]);
    end
  end

  // Masks (1 = masked) and JTAG takeover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_one_reg <= MASK_RESET;
      mask_two_reg <= MASK_RESET;
      jtag_en_reg  <= 1'b0;
    end else if (wr_en) begin
      if (idx == IDX_MASK_ONE) mask_one_reg <= pwdata[NEVENTS-1:0]; // R18
      if (idx == IDX_MASK_TWO) mask_two_reg <= pwdata[NEVENTS-1:0]; // R18
      if (idx == IDX_JTAG) jtag_en_reg <= pwdata[0];
    end
  end

  // Loop pin-clock controls; changing the divider while enabled may glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg[0] <= DIV_RESET; // R19
      div_reg[1] <= DIV_RESET; // R19
      clk_en_reg <= 2'b00;     // R20
    end else if (wr_en) begin
      if (idx == IDX_LOOP1_CLK) begin
        div_reg[0]    <= pwdata[DIV_LSB+:7];
        clk_en_reg[0] <= pwdata[ENA_BIT];
      end
      if (idx == IDX_LOOP2_CLK) begin
        div_reg[1]    <= pwdata[DIV_LSB+:7];
        clk_en_reg[1] <= pwdata[ENA_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Input synchronisers: pins, loop clocks, lock flags
  // ----------------------------------------------------------------------
  // A bit changes once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 20'h00000;
      sync2_reg <= 20'h00000;
      sync3_reg <= 20'h00000;
      filt_reg  <= 20'h00000;
    end else begin
      sync1_reg <= {loop_lock, loop_clk, pad_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
    end
  end

  assign in_level = filt_reg[NPINS-1:0];
  assign dsp_in   = in_level;

  // ----------------------------------------------------------------------
  // Debounce per pin
  // ----------------------------------------------------------------------
  // Debounce is optional; software is expected to turn it on for buttons
  for (genvar g = 0; g < NPINS; g++) begin : g_deb
    logic [15:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg    <= 16'h0000;
        deb_reg[g] <= 1'b0;
      end else if (!cfg_reg[g].deb_en || (in_level[g] == deb_reg[g])) begin
        cnt_reg    <= 16'h0000;
        deb_reg[g] <= in_level[g];
      end else if (cnt_reg == 16'(DEB_CYC - 1)) begin
        cnt_reg    <= 16'h0000;
        deb_reg[g] <= in_level[g];
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sticky events and request lines
  // ----------------------------------------------------------------------
  // Edges of input-mode pins and of the lock flags; set beats clear
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      event_set[i] = (deb_reg[i] ^ deb_d_reg[i]) & cfg_reg[i].dir &
                     (cfg_reg[i].fn == FN_LEVEL); // R11
    end
    event_set[NPINS+:2] = filt_reg[18+:2] ^ lock_d_reg; // R24
    event_clr = (wr_en && idx == IDX_EVENT) ? pwdata[NEVENTS-1:0] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_reg  <= '0;
      deb_d_reg  <= '0;
      lock_d_reg <= 2'b00;
    end else begin
      event_reg  <= (event_reg & ~event_clr) | event_set; // R11 R24
      deb_d_reg  <= deb_reg;
      lock_d_reg <= filt_reg[18+:2];
    end
  end

  assign request_line_one = |(event_reg & ~mask_one_reg); // R16 R18
  assign request_line_two = |(event_reg & ~mask_two_reg); // R16 R18
  assign irq_pin          = request_line_one;             // R17

  // ----------------------------------------------------------------------
  // Loop pin-clock dividers
  // ----------------------------------------------------------------------
  // Counts sampled loop-clock rises; the loop itself is never touched
  for (genvar l = 0; l < 2; l++) begin : g_div
    logic       clk_d_reg;
    logic [6:0] cnt_reg;
    logic [6:0] div_eff;
    assign div_eff = (div_reg[l] < DIV_MIN) ? DIV_MIN : div_reg[l]; // R19
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        clk_d_reg   <= 1'b0;
        cnt_reg     <= 7'h00;
        gclk_reg[l] <= 1'b0;
      end else begin
        clk_d_reg <= filt_reg[NPINS+l];
        if (filt_reg[NPINS+l] & ~clk_d_reg) begin
          cnt_reg <= (cnt_reg >= div_eff - 7'h01) ? 7'h00 : cnt_reg + 7'h01; // R21
        end
        gclk_reg[l] <= clk_en_reg[l] & (cnt_reg < (div_eff >> 1)); // R20
      end
    end
  end

  // ----------------------------------------------------------------------
  // Alternate function wiring
  // ----------------------------------------------------------------------
  // Pins 1 and 2 have no alternate; 3 and 4 carry the speaker port
  assign alt_val[1:0] = 2'b00;                                    // R1
  assign alt_drv[1:0] = 2'b00;                                    // R1
  assign alt_val[3:2] = {speaker_pdm_data, speaker_pdm_clock};    // R7
  assign alt_drv[3:2] = 2'b11;                                    // R7

  // Audio port p uses pins 5+4p .. 8+4p: tx, bit clock, rx, frame clock
  for (genvar p = 0; p < 3; p++) begin : g_aif
    localparam int B = 4 + 4 * p;
    assign alt_val[B]   = aif_from_core[p].tx;                    // R4 R5 R6
    assign alt_drv[B]   = 1'b1;
    assign alt_val[B+1] = aif_from_core[p].bclk;
    assign alt_drv[B+1] = aif_from_core[p].bclk_drv;
    assign alt_val[B+2] = 1'b0;
    assign alt_drv[B+2] = 1'b0;
    assign alt_val[B+3] = aif_from_core[p].frm;
    assign alt_drv[B+3] = aif_from_core[p].frm_drv;
    assign aif_to_core[p].rx   = in_level[B+2] & alt_sel[B+2];
    assign aif_to_core[p].bclk = in_level[B+1] & alt_sel[B+1];
    assign aif_to_core[p].frm  = in_level[B+3] & alt_sel[B+3];
  end

  assign jtag_in = in_level[14:13] & {2{jtag_en_reg}};            // R8

  // ----------------------------------------------------------------------
  // Per-pin output multiplexer
  // ----------------------------------------------------------------------
  // Open drain only applies outside the alternate function
  always_comb begin
    logic v;
    logic en;
    logic low_four;
    v = 1'b0;
    en = 1'b0;
    low_four = 1'b0;
    for (int i = 0; i < NPINS; i++) begin
      v        = 1'b0;
      en       = 1'b0;
      low_four = LOW_FOUR_PINS[i];
      alt_sel[i] = 1'b0;
      if (jtag_en_reg && JTAG_PINS[i]) begin
        en = JTAG_OUT_PINS[i];                                    // R8
        v  = jtag_tdo;
      end else begin
        case (cfg_reg[i].fn)
          FN_ALT: begin
            alt_sel[i] = ALT_OUT_PINS[i] | ALT_IO_PINS[i] | ALT_IN_PINS[i]; // R2
            en = alt_drv[i];                                      // R3
            v  = alt_val[i];
          end
          FN_LEVEL: begin
            en = ~cfg_reg[i].dir;
            v  = cfg_reg[i].lvl ^ cfg_reg[i].pol;                 // R12 R14
          end
          FN_DSP: begin
            en = dsp_drive[i];                                    // R15
            v  = dsp_out[i];
          end
          FN_REQ_ONE, FN_REQ_TWO: begin
            en = ~cfg_reg[i].dir;
            v  = cfg_reg[i].fn[2] ? request_line_two : request_line_one; // R16
          end
          FN_LOOP1_CLK, FN_LOOP2_CLK: begin
            en = ~cfg_reg[i].dir & low_four;
            v  = cfg_reg[i].fn[0] ? gclk_reg[1] : gclk_reg[0];    // R19
          end
          FN_LOOP1_LOCK, FN_LOOP2_LOCK: begin
            en = ~cfg_reg[i].dir & low_four;
            v  = cfg_reg[i].fn[0] ? filt_reg[19] : filt_reg[18];  // R23
          end
          default: begin
            en = 1'b0;
            v  = 1'b0;
          end
        endcase
        if (cfg_reg[i].odrain && (cfg_reg[i].fn != FN_ALT)) begin
          en = en & ~v;                                           // R3
        end
      end
      pad_out_next[i]  = v & en;
      pad_oe_n_next[i] = ~en;
    end
  end

  // Registered pad drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out_reg  <= '0;
      pad_oe_n_reg <= '1;
    end else begin
      pad_out_reg  <= pad_out_next;
      pad_oe_n_reg <= pad_oe_n_next;
    end
  end

  assign pad_out  = pad_out_reg;
  assign pad_oe_n = pad_oe_n_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_pin_tie: assert property (irq_pin == request_line_one) // R17
    else $error("dedicated pin does not follow request one");
  a_lock_event: assert property ($rose(filt_reg[18]) |=> event_reg[NPINS]) // R24
    else $error("lock rise did not latch an event");
  a_event_sticky: assert property (event_reg[1] && !event_clr[1] |=> event_reg[1]) // R11
    else $error("pin event dropped without clear");
  a_gate_off: assert property (!clk_en_reg[0] |=> !gclk_reg[0]) // R20
    else $error("loop clock output while disabled");
  a_level_drive: assert property (cfg_reg[0].fn == FN_LEVEL && !cfg_reg[0].dir &&
                                  !cfg_reg[0].odrain
                                  |=> !pad_oe_n[0] &&
                                      pad_out[0] == ($past(cfg_reg[0].lvl) ^
                                                     $past(cfg_reg[0].pol))) // R12 R14
    else $error("logic output level wrong");
  a_alt_tx_drive: assert property (cfg_reg[4].fn == FN_ALT |=> !pad_oe_n[4]) // R3
    else $error("transmit pin not driven in alternate mode");
  a_jtag_input: assert property (jtag_en_reg |=> pad_oe_n[13] && pad_oe_n[14]) // R8
    else $error("pin driven while JTAG owns it");
  a_level_wo: assert property (rd_setup && !pwrite && mapped && idx == IDX_PIN_CFG0 &&
                               !cfg_reg[0].dir |=> !prdata[11]) // R13
    else $error("output pin level readable");
  a_req_two_pin: assert property (cfg_reg[1].fn == FN_REQ_TWO && !cfg_reg[1].dir &&
                                  !cfg_reg[1].odrain
                                  |=> pad_out[1] == $past(request_line_two)) // R16
    else $error("request two not on pin");

  c_event_clear: cover property (event_reg[1] ##1 !event_reg[1]);
  c_gclk_run: cover property (!gclk_reg[0] ##1 gclk_reg[0] ##1 !gclk_reg[0]);
  c_unmapped: cover property (pready && pslverr);
  c_req_one: cover property ($rose(request_line_one));

endmodule : gfm_top

// *** test/gfm_pin_partner.sv ***
// Pin-side model: buttons, audio peers and loads on the sixteen pins
`timescale 1ns/10ps
module gfm_pin_partner
  import gfm_pkg::*;
(
  input  wire logic [NPINS-1:0] pad_out,
  input  wire logic [NPINS-1:0] pad_oe_n,
  input  wire logic             pclk,
  input  wire logic [NPINS-1:0] ext_drv,
  input  wire logic [NPINS-1:0] ext_val,
  output      logic [NPINS-1:0] pad_in
);
  logic [NPINS-1:0] churn_reg = '0;
  // No keeper on the board, so a floating pin must not look stable
  always_ff @(posedge pclk) begin
    churn_reg <= ~churn_reg;
  end
  // Device drive wins, then an external driver, else the churn
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      pad_in[i] = !pad_oe_n[i] ? pad_out[i] : (ext_drv[i] ? ext_val[i] : churn_reg[i]);
    end
  end
endmodule : gfm_pin_partner

// *** test/tb_top.sv ***
// Self-checking bench for the pin function multiplexer
`timescale 1ns/10ps
module tb_top;
  import gfm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, jtag_tdo, r1, r2, irq;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NPINS-1:0] pad_in, pad_out, pad_oe_n, ext_drv, ext_val, dsp_out, dsp_drive, din;
  logic [1:0] loop_clk, loop_lock, jin;
  logic [3:0] lc = '0;
  gfm_aif_out_t [2:0] aif;
  gfm_aif_in_t [2:0] ain;
  int failures, checks, hi;
  // Rows: pin index, config word, expected {oe_n, out}
  localparam logic [21:0] ROWS [11] = '{{4'h0, 16'h0801, 2'b01}, {4'h1, 16'h2001, 2'b01},
    {4'h2, 16'h4000, 2'b01}, {4'h3, 16'h0000, 2'b00}, {4'h4, 16'h0000, 2'b01},
    {4'h6, 16'h0000, 2'b10}, {4'h8, 16'h1000, 2'b01}, {4'hC, 16'h0000, 2'b01},
    {4'hF, 16'h0002, 2'b01}, {4'h5, 16'h0003, 2'b00}, {4'h1, 16'h0004, 2'b00}};
  gfm_top #(.DEB_CYC(4)) gfm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .aif_from_core(aif), .aif_to_core(ain), .speaker_pdm_clock(1'b1),
    .speaker_pdm_data(1'b0), .dsp_out(dsp_out), .dsp_drive(dsp_drive), .dsp_in(din),
    .jtag_tdo(jtag_tdo), .jtag_in(jin), .loop_clk(loop_clk), .loop_lock(loop_lock),
    .request_line_one(r1), .request_line_two(r2), .irq_pin(irq));
  gfm_pin_partner gfm_pin_partner_i (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pclk(pclk),
    .ext_drv(ext_drv), .ext_val(ext_val), .pad_in(pad_in));
  // Slow loop clocks, well under a third of pclk so sampling holds
  always @(posedge pclk) begin
    lc <= lc + 4'h1;
    loop_clk <= {2{lc[2]}};
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high
  task automatic xf(input logic w, input logic [15:0] i, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : xf
  // Two settling edges first, so the enable latency stays out of the window
  task automatic count_hi;
    repeat (2) @(posedge pclk);
    hi = 0;
    repeat (64) begin @(posedge pclk); hi += int'(pad_out[0] === 1'b1); end
  endtask : count_hi
  task automatic end_sim;
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin pclk = 1'b0; forever #5 pclk = ~pclk; end
  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin #200000; failures++; end_sim(); end
  initial begin
    presetn = 1'b0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    jtag_tdo = 0; ext_drv = 16'h6042; ext_val = 16'h6040; loop_clk = '0; loop_lock = '0;
    dsp_out = 16'h8000; dsp_drive = 16'h8000; aif = {3{5'b10000}};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    xf(0, 16'h0005, 0); chk(rd, 32'h4001);
    chk(er, 0);
    xf(0, IDX_LOOP1_CLK, 0); chk(rd, 32'h0004);
    xf(0, IDX_MASK_ONE, 0); chk(rd, 32'h3FFFF);
    xf(0, 16'h0100, 0); chk(er, 1);
    for (int k = 0; k < 11; k++) begin
      xf(1, {12'h000, ROWS[k][21:18]}, {16'h0000, ROWS[k][17:2]});
      repeat (2) @(posedge pclk);
      chk({pad_oe_n[ROWS[k][21:18]], pad_out[ROWS[k][21:18]]}, ROWS[k][1:0]);
    end
    xf(0, 16'h0000, 0); chk(rd, 32'h0001);
    chk(ain[0].rx, 1);
    chk(din[6], 1);
    xf(1, IDX_JTAG, 1); repeat (2) @(posedge pclk);
    chk({pad_oe_n[13:12], pad_out[12]}, 3'b100);
    chk(jin, 2'b11);
    xf(1, 16'h0001, 32'h4401); repeat (20) @(posedge pclk);
    xf(1, IDX_EVENT, 32'h3FFFF); xf(1, IDX_MASK_ONE, 32'h3FFFD);
    chk(r1, 0);
    ext_val[1] <= 1'b1; repeat (20) @(posedge pclk);
    xf(0, 16'h0001, 0); chk(rd, 32'h4C01);
    chk({r1, irq, r2}, 3'b110);
    xf(1, IDX_EVENT, 32'h2); chk(r1, 0);
    xf(1, 16'h0000, 32'h0018); loop_lock[0] <= 1'b1; repeat (10) @(posedge pclk);
    chk(pad_out[0], 1);
    xf(0, IDX_EVENT, 0); chk(rd[17:16], 2'b01);
    xf(1, 16'h0000, 32'h0010); count_hi(); chk(hi, 0);
    xf(1, IDX_LOOP1_CLK, 32'h0005); count_hi(); chk(hi, 32);
    xf(1, IDX_LOOP1_CLK, 32'h0006);
    xf(1, IDX_LOOP1_CLK, 32'h0007); count_hi(); chk(hi >= 16 && hi <= 24, 1);
    // Mid-run reset: pads released at once, registers back to reset values
    presetn <= 1'b0; @(posedge pclk);
    chk({pad_oe_n, r1, irq}, {16'hFFFF, 2'b00});
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xf(0, 16'h0000, 0); chk(rd, 32'h4001);
    xf(0, IDX_LOOP1_CLK, 0); chk(rd, 32'h0004);
    end_sim();
  end
endmodule : tb_top
